/* File: hdl/mac_debug_observation.sv */
// Debug observation block: state snapshot registers, probe configuration and probe multiplexer.
`timescale 1ns/100ps

module mac_debug_observation
  import mac_debug_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CLK_EN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [31:0] RX_BUFFER_ADDRESS,
  input wire fsm_states_t FSM_STATES,
  input wire probe_signals_t PROBE_SIGNALS,
  output logic [15:0] DEBUG_PROBE,
  output logic [1:0] TRIGGER_FLAG,
  output logic [1:0] STIMULUS_ENABLE
);

  // Whole state of the block.
  typedef struct packed {
    logic [31:0] rx_buffer_current_address;
    logic [31:0] rx_state_snapshot;
    logic [31:0] tx_state_snapshot;
    logic [31:0] misc_state_snapshot_a;
    logic [31:0] misc_state_snapshot_b;
    logic [31:0] debug_probe_config;
    logic [15:0] probe;
    logic write_pending;
    logic [31:0] write_address;
    logic [31:0] read_data;
  } state_t;

  state_t state;
  state_t next_state;
  logic access;
  logic [15:0] group_bits;
  logic [31:0] read_word;
  logic [5:0] group_select;
  logic [1:0] flags;

  assign group_select = state.debug_probe_config[GROUP_SELECT_LSB +: 6];
  assign flags = state.debug_probe_config[TRIGGER_FLAG_LSB +: 2];
  assign access = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ || HTRANS == HTRANS_SEQ);

  // Probe multiplexer choosing one sixteen-signal group.
  always_comb begin
    group_bits = 16'h0000;
    case (group_select)
      GROUP_BUS_MASTER: begin
        group_bits = {flags[0], PROBE_SIGNALS.bus_transfer_done, PROBE_SIGNALS.bus_grant_lost,
                      PROBE_SIGNALS.bus_transfer_counter, PROBE_SIGNALS.bus_last_beat,
                      PROBE_SIGNALS.transfer_counter_expired,
                      FSM_STATES.bus_master_state};
      end
      GROUP_TX_DMA: begin
        group_bits = {flags[0], FSM_STATES.transmit_buffer_state,
                      FSM_STATES.transmit_dma_state};
      end
      GROUP_RX_DMA: begin
        group_bits = {flags[0], FSM_STATES.receive_buffer_state,
                      FSM_STATES.receive_dma_state};
      end
      GROUP_QUEUE_CTRL: begin
        group_bits = {flags[0], PROBE_SIGNALS.tx_queue_high_mark, PROBE_SIGNALS.tx_queue_low_mark,
                      FSM_STATES.transmit_fifo_ctrl_state,
                      FSM_STATES.receive_fifo_ctrl_state};
      end
      GROUP_TX_QUEUE: begin
        group_bits = {PROBE_SIGNALS.tx_buffer_data_ready, PROBE_SIGNALS.tx_queue_write_pointer,
                      PROBE_SIGNALS.transmit_start_request, PROBE_SIGNALS.transmit_start_flag,
                      PROBE_SIGNALS.tx_queue_read_strobe,
                      PROBE_SIGNALS.tx_queue_read_pointer};
      end
      GROUP_RX_QUEUE: begin
        group_bits = {PROBE_SIGNALS.rx_queue_write_strobe, PROBE_SIGNALS.rx_queue_write_pointer,
                      PROBE_SIGNALS.rx_queue_high_mark, PROBE_SIGNALS.rx_queue_low_mark,
                      PROBE_SIGNALS.rx_buffer_acknowledge,
                      PROBE_SIGNALS.rx_queue_read_pointer};
      end
      default: begin
        group_bits = 16'h0000;
      end
    endcase
  end

  // Register read decode; unmapped addresses read zero.
  always_comb begin
    case (HADDR)
      RX_BUFFER_CURRENT_ADDRESS_ADDR: read_word = state.rx_buffer_current_address;
      RX_STATE_SNAPSHOT_ADDR: read_word = state.rx_state_snapshot;
      TX_STATE_SNAPSHOT_ADDR: read_word = state.tx_state_snapshot;
      MISC_STATE_SNAPSHOT_A_ADDR: read_word = state.misc_state_snapshot_a;
      MISC_STATE_SNAPSHOT_B_ADDR: read_word = state.misc_state_snapshot_b;
      DEBUG_PROBE_CONFIG_ADDR: read_word = state.debug_probe_config;
      default: read_word = 32'h00000000;
    endcase
  end

  // Next-state logic: snapshots follow the machines, the bus writes the configuration.
  always_comb begin
    next_state = state;
    // Snapshots are loaded only from the machines, never from the bus.
    next_state.rx_buffer_current_address = RX_BUFFER_ADDRESS;
    next_state.rx_state_snapshot = {FSM_STATES.receive_dma_state, 1'b0,
                                    FSM_STATES.receive_buffer_state,
                                    FSM_STATES.receive_desc_fetch_state,
                                    FSM_STATES.receive_desc_close_state,
                                    FSM_STATES.receive_fifo_ctrl_state};
    next_state.tx_state_snapshot = {FSM_STATES.transmit_dma_state, 2'b00,
                                    FSM_STATES.transmit_buffer_state[5:0],
                                    FSM_STATES.transmit_desc_fetch_state,
                                    FSM_STATES.transmit_desc_close_state, 3'b000,
                                    FSM_STATES.transmit_fifo_ctrl_state};
    next_state.misc_state_snapshot_a = {6'h00, FSM_STATES.transmit_mac_state, 2'b00,
                                        FSM_STATES.transmit_defer_state,
                                        FSM_STATES.mgmt_interface_state};
    next_state.misc_state_snapshot_b = {1'b0, FSM_STATES.internal_arbiter_state,
                                        FSM_STATES.pause_frame_tx_state, 10'h000,
                                        FSM_STATES.bus_master_state, 8'h00};
    next_state.probe = group_bits;
    next_state.write_pending = 1'b0;
    // Address phase: latch reads now, remember writes for the data phase.
    if (access) begin
      next_state.read_data = read_word;
      next_state.write_pending = HWRITE;
      next_state.write_address = HADDR;
    end
    // Data phase of a write; only the configuration register takes data.
    if (state.write_pending && state.write_address == DEBUG_PROBE_CONFIG_ADDR) begin
      next_state.debug_probe_config = HWDATA & DEBUG_PROBE_CONFIG_MASK;
    end
    if (RESET) begin
      next_state.rx_buffer_current_address = RX_BUFFER_CURRENT_ADDRESS_RESET;
      next_state.rx_state_snapshot = RX_STATE_SNAPSHOT_RESET;
      next_state.tx_state_snapshot = TX_STATE_SNAPSHOT_RESET;
      next_state.misc_state_snapshot_a = MISC_STATE_SNAPSHOT_A_RESET;
      next_state.misc_state_snapshot_b = MISC_STATE_SNAPSHOT_B_RESET;
      next_state.debug_probe_config = DEBUG_PROBE_CONFIG_RESET;
      next_state.probe = 16'h0000;
      next_state.write_pending = 1'b0;
      next_state.write_address = 32'h00000000;
      next_state.read_data = 32'h00000000;
    end
  end

  // State register; the clock enable freezes everything except reset.
  always_ff @(posedge CLK) begin
    if (CLK_EN || RESET) begin
      state <= next_state;
    end
  end

  // Outputs; the slave is always ready and always answers OKAY.
  assign HRDATA = state.read_data;
  assign HREADYOUT = 1'b1;
  assign HRESP = HRESP_OKAY;
  assign DEBUG_PROBE = state.probe;
  assign TRIGGER_FLAG = state.debug_probe_config[TRIGGER_FLAG_LSB +: 2];
  assign STIMULUS_ENABLE = state.debug_probe_config[STIMULUS_ENABLE_LSB +: 2];

endmodule : mac_debug_observation

/* File: hdl/mac_debug_pkg.sv */
// Package with register map, field layout, reset values and carrier types of the debug block.
package mac_debug_pkg;

  // Byte addresses of the registers.
  localparam logic [31:0] RX_STATE_SNAPSHOT_ADDR = 32'hfff03200;
  localparam logic [31:0] TX_STATE_SNAPSHOT_ADDR = 32'hfff03204;
  localparam logic [31:0] MISC_STATE_SNAPSHOT_A_ADDR = 32'hfff03208;
  localparam logic [31:0] MISC_STATE_SNAPSHOT_B_ADDR = 32'hfff0320c;
  localparam logic [31:0] DEBUG_PROBE_CONFIG_ADDR = 32'hfff03210;
  localparam logic [31:0] RX_BUFFER_CURRENT_ADDRESS_ADDR = 32'hfff030d8;

  // Values after reset.
  localparam logic [31:0] RX_BUFFER_CURRENT_ADDRESS_RESET = 32'h00000000;
  localparam logic [31:0] RX_STATE_SNAPSHOT_RESET = 32'h00811101;
  localparam logic [31:0] TX_STATE_SNAPSHOT_RESET = 32'h01011101;
  localparam logic [31:0] MISC_STATE_SNAPSHOT_A_RESET = 32'h00010101;
  localparam logic [31:0] MISC_STATE_SNAPSHOT_B_RESET = 32'h11000100;
  localparam logic [31:0] DEBUG_PROBE_CONFIG_RESET = 32'h0000003f;

  // Writable bits of the debug configuration register.
  localparam logic [31:0] DEBUG_PROBE_CONFIG_MASK = 32'h00c000ff;

  // Field positions of the debug configuration register.
  localparam int GROUP_SELECT_LSB = 0;
  localparam int TRIGGER_FLAG_LSB = 6;
  localparam int STIMULUS_ENABLE_LSB = 22;

  // Signal group codes.
  localparam logic [5:0] GROUP_BUS_MASTER = 6'h00;
  localparam logic [5:0] GROUP_TX_DMA = 6'h01;
  localparam logic [5:0] GROUP_RX_DMA = 6'h02;
  localparam logic [5:0] GROUP_QUEUE_CTRL = 6'h03;
  localparam logic [5:0] GROUP_TX_QUEUE = 6'h04;
  localparam logic [5:0] GROUP_RX_QUEUE = 6'h05;

  // AHB transfer type and response codes.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'h0;

  // State codes of the observed machines, as they stand in the controller.
  typedef struct packed {
    logic [8:0] receive_dma_state;
    logic [5:0] receive_buffer_state;
    logic [3:0] receive_desc_fetch_state;
    logic [3:0] receive_desc_close_state;
    logic [7:0] receive_fifo_ctrl_state;
    logic [7:0] transmit_dma_state;
    logic [6:0] transmit_buffer_state;
    logic [3:0] transmit_desc_fetch_state;
    logic [3:0] transmit_desc_close_state;
    logic [4:0] transmit_fifo_ctrl_state;
    logic [9:0] transmit_mac_state;
    logic [5:0] transmit_defer_state;
    logic [7:0] mgmt_interface_state;
    logic [2:0] internal_arbiter_state;
    logic [3:0] pause_frame_tx_state;
    logic [5:0] bus_master_state;
  } fsm_states_t;

  // Miscellaneous internal signals observed through the probe groups.
  typedef struct packed {
    logic bus_transfer_done;
    logic bus_grant_lost;
    logic [4:0] bus_transfer_counter;
    logic bus_last_beat;
    logic transfer_counter_expired;
    logic tx_queue_high_mark;
    logic tx_queue_low_mark;
    logic tx_buffer_data_ready;
    logic [5:0] tx_queue_write_pointer;
    logic transmit_start_flag;
    logic transmit_start_request;
    logic tx_queue_read_strobe;
    logic [5:0] tx_queue_read_pointer;
    logic rx_queue_write_strobe;
    logic [5:0] rx_queue_write_pointer;
    logic rx_queue_high_mark;
    logic rx_queue_low_mark;
    logic rx_buffer_acknowledge;
    logic [5:0] rx_queue_read_pointer;
  } probe_signals_t;

endpackage : mac_debug_pkg

/* File: tb/state_source_model.sv */
// Model of the controller machines and signals that the debug block observes.
`timescale 1ns/100ps
module state_source_model
  import mac_debug_pkg::*;
(
  input wire logic clk,
  input wire logic step,
  output logic [31:0] rx_address,
  output fsm_states_t fsm_states,
  output probe_signals_t probe
);
  int seed = 32'hf131;
  logic [63:0] r;
  // New random codes at each step request; they hold otherwise.
  always @(posedge clk) begin
    if (step) begin
      rx_address <= $random(seed);
      fsm_states <= {$random(seed), $random(seed), $random(seed)};
      r = {$random(seed), $random(seed)};
      probe <= r[$bits(probe_signals_t)-1:0];
    end
  end
endmodule : state_source_model

/* File: tb/mac_debug_observation_chk.sv */
// Checker of the probe outputs of the debug block.
`timescale 1ns/100ps
module mac_debug_observation_chk
  import mac_debug_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CLK_EN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire fsm_states_t FSM_STATES,
  input wire probe_signals_t PROBE_SIGNALS,
  input wire logic [15:0] DEBUG_PROBE,
  input wire logic [1:0] TRIGGER_FLAG,
  input wire logic [1:0] STIMULUS_ENABLE
);
  logic wr, en;
  logic [31:0] cfg, pc;
  fsm_states_t s;
  probe_signals_t p;
  // Shadow of the configuration and one-cycle-old copies of the probe sources.
  always_ff @(posedge CLK) begin
    s <= FSM_STATES;
    p <= PROBE_SIGNALS;
    pc <= cfg;
    en <= CLK_EN;
    if (RESET) begin
      wr <= 1'b0;
      cfg <= DEBUG_PROBE_CONFIG_RESET;
    end else if (CLK_EN) begin
      wr <= HSEL && HREADY && HTRANS[1] && HWRITE && HADDR == DEBUG_PROBE_CONFIG_ADDR;
      if (wr) begin
        cfg <= HWDATA & DEBUG_PROBE_CONFIG_MASK;
      end
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  a_flag_follow: assert property (TRIGGER_FLAG == cfg[7:6])
    else $error("trigger flags differ from configuration");
  a_enable_follow: assert property (STIMULUS_ENABLE == cfg[23:22])
    else $error("stimulus enables differ from configuration");
  a_after_reset: assert property ($past(RESET) |-> DEBUG_PROBE == 16'h0 && !TRIGGER_FLAG)
    else $error("outputs not cleared by reset");
  a_undef_zero: assert property (en && pc[5:0] > GROUP_RX_QUEUE |-> DEBUG_PROBE == 16'h0)
    else $error("undefined group not zero");
  a_group_bus: assert property (en && pc[5:0] == GROUP_BUS_MASTER |-> DEBUG_PROBE ==
    {pc[6], p.bus_transfer_done, p.bus_grant_lost, p.bus_transfer_counter, p.bus_last_beat,
    p.transfer_counter_expired, s.bus_master_state}) else $error("group 0 wrong");
  a_group_txdma: assert property (en && pc[5:0] == GROUP_TX_DMA |-> DEBUG_PROBE ==
    {pc[6], s.transmit_buffer_state, s.transmit_dma_state}) else $error("group 1 wrong");
  a_group_rxdma: assert property (en && pc[5:0] == GROUP_RX_DMA |-> DEBUG_PROBE ==
    {pc[6], s.receive_buffer_state, s.receive_dma_state}) else $error("group 2 wrong");
  a_group_queue: assert property (en && pc[5:0] == GROUP_QUEUE_CTRL |-> DEBUG_PROBE ==
    {pc[6], p.tx_queue_high_mark, p.tx_queue_low_mark, s.transmit_fifo_ctrl_state,
    s.receive_fifo_ctrl_state}) else $error("group 3 wrong");
  a_freeze_hold: assert property (!CLK_EN |=> $stable(DEBUG_PROBE) && $stable(TRIGGER_FLAG))
    else $error("outputs moved while clock enable low");
  c_group_rxq: cover property (pc[5:0] == GROUP_RX_QUEUE);
  c_flags_set: cover property (TRIGGER_FLAG == 2'h3);
  c_collide_on: cover property (STIMULUS_ENABLE[0]);
endmodule : mac_debug_observation_chk
bind mac_debug_observation mac_debug_observation_chk i_chk (.CLK, .RESET, .CLK_EN, .HSEL,
  .HADDR, .HTRANS, .HWRITE, .HWDATA, .HREADY, .FSM_STATES, .PROBE_SIGNALS, .DEBUG_PROBE,
  .TRIGGER_FLAG, .STIMULUS_ENABLE);

/* File: tb/mac_debug_observation_tb_top.sv */
// Testbench of the debug observation block.
`timescale 1ns/100ps
module mac_debug_observation_tb_top;
  import mac_debug_pkg::*;
  logic CLK = 0, RESET = 1, CLK_EN = 1, HSEL = 0, HWRITE = 0, step = 1, rd_ph = 0, pr_ph = 0;
  logic [1:0] HTRANS = 2'h0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rxa;
  logic HREADYOUT, HRESP;
  logic [15:0] DEBUG_PROBE;
  logic [1:0] TRIGGER_FLAG, STIMULUS_ENABLE;
  logic [5:0] gv;
  logic [15:0] fz;
  fsm_states_t fs;
  probe_signals_t ps;
  logic [31:0] q_rd[$], q_pr[$];
  logic [31:0] ra[6] = '{RX_STATE_SNAPSHOT_ADDR, TX_STATE_SNAPSHOT_ADDR,
    MISC_STATE_SNAPSHOT_A_ADDR, MISC_STATE_SNAPSHOT_B_ADDR, RX_BUFFER_CURRENT_ADDRESS_ADDR,
    32'hfff03218};
  int n_fail = 0, checks = 0;
  always #25 CLK = ~CLK;
  mac_debug_observation i_dut (.CLK, .RESET, .CLK_EN, .HSEL, .HADDR, .HTRANS, .HWRITE,
    .HSIZE(3'h2), .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP,
    .RX_BUFFER_ADDRESS(rxa), .FSM_STATES(fs), .PROBE_SIGNALS(ps), .DEBUG_PROBE,
    .TRIGGER_FLAG, .STIMULUS_ENABLE);
  state_source_model i_src (.clk(CLK), .step, .rx_address(rxa), .fsm_states(fs), .probe(ps));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // Results stand through the data phase, so they are taken at the falling edge.
  always @(negedge CLK) begin
    if (rd_ph) cmp(HRDATA, q_rd.pop_front());
    if (pr_ph) cmp({16'h0, DEBUG_PROBE}, q_pr.pop_front());
  end
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= HTRANS_NONSEQ;
    HADDR <= a;
    HWRITE <= w;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    rd_ph <= !w;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    rd_ph <= 1'b0;
  endtask : ahb
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    q_rd.push_back(e);
    ahb(1'b0, a, 32'h0);
  endtask : rd
  task automatic pchk(input logic [31:0] e);
    q_pr.push_back(e);
    pr_ph <= 1'b1;
    @(posedge CLK);
    pr_ph <= 1'b0;
  endtask : pchk
  function automatic logic [31:0] snap(input int k);
    case (k)
      0: snap = {fs.receive_dma_state, 1'b0, fs.receive_buffer_state,
        fs.receive_desc_fetch_state, fs.receive_desc_close_state, fs.receive_fifo_ctrl_state};
      1: snap = {fs.transmit_dma_state, 2'b0, fs.transmit_buffer_state[5:0],
        fs.transmit_desc_fetch_state, fs.transmit_desc_close_state, 3'b0,
        fs.transmit_fifo_ctrl_state};
      2: snap = {6'b0, fs.transmit_mac_state, 2'b0, fs.transmit_defer_state,
        fs.mgmt_interface_state};
      3: snap = {1'b0, fs.internal_arbiter_state, fs.pause_frame_tx_state, 10'b0,
        fs.bus_master_state, 8'b0};
      4: snap = rxa;
      default: snap = 32'h0;
    endcase
  endfunction : snap
  function automatic logic [15:0] grp(input logic [5:0] g, input logic f);
    case (g)
      6'h03: grp = {f, ps.tx_queue_high_mark, ps.tx_queue_low_mark, fs.transmit_fifo_ctrl_state,
        fs.receive_fifo_ctrl_state};
      6'h04: grp = {ps.tx_buffer_data_ready, ps.tx_queue_write_pointer, ps.transmit_start_request,
        ps.transmit_start_flag, ps.tx_queue_read_strobe, ps.tx_queue_read_pointer};
      6'h05: grp = {ps.rx_queue_write_strobe, ps.rx_queue_write_pointer, ps.rx_queue_high_mark,
        ps.rx_queue_low_mark, ps.rx_buffer_acknowledge, ps.rx_queue_read_pointer};
      default: grp = 16'h0;
    endcase
  endfunction : grp
  task automatic test_done;
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  // Stops a hung run.
  initial begin
    #(50 * 5000);
    n_fail++;
    test_done();
  end
  // Registers first, then every probe group with changing flags and enables.
  initial begin
    repeat (20) @(posedge CLK);
    RESET <= 1'b0;
    step <= 1'b0;
    @(posedge CLK);
    rd(DEBUG_PROBE_CONFIG_ADDR, DEBUG_PROBE_CONFIG_RESET);
    for (int i = 0; i < 3; i++) begin
      for (int k = 0; k < 6; k++) ahb(1'b1, ra[k], 32'hffffffff);
      for (int k = 0; k < 6; k++) rd(ra[k], snap(k));
      ahb(1'b1, DEBUG_PROBE_CONFIG_ADDR, 32'hffffffff);
      rd(DEBUG_PROBE_CONFIG_ADDR, 32'h00c000ff);
      step <= 1'b1;
      @(posedge CLK);
      step <= 1'b0;
      repeat (2) @(posedge CLK);
    end
    $display("test registers done");
    for (int g = 0; g < 8; g++) begin
      gv = (g == 7) ? 6'h3f : g[5:0];
      ahb(1'b1, DEBUG_PROBE_CONFIG_ADDR, {8'h0, g[1:0], 14'h0, g[1:0], gv});
      step <= 1'b1;
      @(posedge CLK);
      step <= 1'b0;
      repeat (3) @(posedge CLK);
      if (g > 2) pchk(grp(gv, g[0]));
    end
    $display("test groups done");
    // Clock enable low must freeze the probe while the sources change.
    ahb(1'b1, DEBUG_PROBE_CONFIG_ADDR, 32'h00000004);
    repeat (2) @(posedge CLK);
    fz = grp(6'h04, 1'b0);
    CLK_EN <= 1'b0;
    step <= 1'b1;
    @(posedge CLK);
    step <= 1'b0;
    repeat (3) @(posedge CLK);
    pchk({16'h0, fz});
    CLK_EN <= 1'b1;
    $display("test freeze done");
    test_done();
  end
endmodule : mac_debug_observation_tb_top
